// >>> src/miiphy_pkg.sv
// Functional notes
// - Outgoing frame data leaves as four-bit nibbles on the transmit data lines.
// - Transmit enable is high exactly while a valid nibble is presented.
// - Transmit error flags a bad condition in the nibble being sent.
// - PHY supplies transmit clock at 25 or 2.5 MHz; outputs follow it.
// - PHY supplies receive clock at 25 or 2.5 MHz; capture follows it.
// - Receive nibbles are accepted only while receive data valid is high.
// - A receive error during a frame marks the whole frame as errored.
// - Collision is acted on in half duplex only, ignored in full duplex.
// - Carrier sense defers transmit in half duplex only, ignored in full.
// - Duplex input high means full duplex, low means half duplex.
// - An active-low reset output can hold the PHY in reset.
// - The active-low PHY interrupt input is reported as an event.
// - Management clock is driven out; management data uses the shared line.
// - Management data idles high: released when not driven, pulled up.
// - Read of an absent PHY returns ffff with pull-up, 0000 with pull-down.
// - A continuous 25 MHz reference clock is driven to the PHY.
// - The PHY 125 MHz clock may serve for reduced-pin transmit clocking; here it is only monitored for activity.
package miiphy_pkg;

  // System clock and derived reference divider
  localparam int unsigned SYS_CLK_HZ    = 200_000_000;
  localparam int unsigned REF_CLK_HZ    = 25_000_000;
  localparam int unsigned REF_HALF_CYC  = SYS_CLK_HZ / (2 * REF_CLK_HZ);
  localparam int unsigned REF_CNT_W     = 3;

  // Management clock: fastest rate, half period rounded up in cycles
  localparam int unsigned MDC_MAX_HZ    = 2_500_000;
  localparam int unsigned MDC_HALF_CYC  = (SYS_CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);

  // Management frame layout, bit counts from the first preamble bit
  localparam int unsigned MDIO_PRE_BITS   = 32;
  localparam int unsigned MDIO_FRAME_BITS = 64;
  localparam int unsigned MDIO_RD_DRIVE   = 46;
  localparam int unsigned MDIO_DATA_START = 48;
  localparam logic [1:0]  MDIO_START      = 2'h1;
  localparam logic [1:0]  MDIO_OP_READ    = 2'h2;
  localparam logic [1:0]  MDIO_OP_WRITE   = 2'h1;
  localparam logic [1:0]  MDIO_TA_WRITE   = 2'h2;
  localparam logic [1:0]  MDIO_TA_READ    = 2'h3;
  localparam logic [15:0] MDIO_IDLE_DATA  = 16'hffff;

  // Activity window for the fast PHY clock, in ns and in cycles
  localparam int unsigned FAST_ALIVE_NS  = 320;
  localparam int unsigned FAST_ALIVE_CYC = FAST_ALIVE_NS * (SYS_CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned FAST_CNT_W     = 7;

  // Data path widths
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned PHY_AW   = 5;
  localparam int unsigned MDIO_DW  = 16;

  typedef enum logic {MIIPHY_MDIO_IDLE, MIIPHY_MDIO_RUN} miiphy_mdio_state_type;

endpackage : miiphy_pkg

// >>> src/miiphy_mgmt_if.sv
`timescale 1ns/1ps
// Management request and answer between the attach top and the engine
interface miiphy_mgmt_if;
  logic        req;
  logic        write;
  logic [4:0]  phy_addr;
  logic [4:0]  reg_addr;
  logic [15:0] wdata;
  logic        busy;
  logic        done;
  logic [15:0] rdata;

  modport requester (output req, output write, output phy_addr, output reg_addr,
                     output wdata, input busy, input done, input rdata);
  modport engine    (input req, input write, input phy_addr, input reg_addr,
                     input wdata, output busy, output done, output rdata);
endinterface : miiphy_mgmt_if

// >>> src/miiphy_mdio.sv
`timescale 1ns/1ps
// Serial management engine: one clause-22 style frame per request
module miiphy_mdio #(
  parameter int unsigned HALF_CYC = miiphy_pkg::MDC_HALF_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  miiphy_mgmt_if.engine         mgmt,
  output logic                  mdc_out,
  input  wire logic             mdio_in,
  output logic                  mdio_out,
  output logic                  mdio_oe
);

  localparam int unsigned DIV_W = $clog2(HALF_CYC + 1);

  typedef struct packed {
    miiphy_pkg::miiphy_mdio_state_type state;
    logic [DIV_W-1:0] div;
    logic             mdc;
    logic [6:0]       bit_cnt;
    logic [63:0]      shreg;
    logic             wr;
    logic [15:0]      rdata;
    logic             done;
    logic             mdio_s1;
    logic             mdio_s2;
    logic             dout;
    logic             oe;
  } miiphy_mdio_reg_type;

  miiphy_mdio_reg_type s_reg;
  miiphy_mdio_reg_type s_next;

  // Frame sequencing; data changes on the falling edge, PHY samples on rising
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.mdio_s1 = mdio_in;
    s_next.mdio_s2 = s_reg.mdio_s1;
    case (s_reg.state)
      miiphy_pkg::MIIPHY_MDIO_IDLE: begin
        s_next.oe = 1'b0;
        s_next.dout = 1'b1;
        if (mgmt.req) begin
          s_next.state = miiphy_pkg::MIIPHY_MDIO_RUN;
          s_next.wr = mgmt.write;
          s_next.div = '0;
          s_next.mdc = 1'b0;
          s_next.bit_cnt = '0;
          s_next.shreg = {{miiphy_pkg::MDIO_PRE_BITS{1'b1}}, miiphy_pkg::MDIO_START,
                          mgmt.write ? miiphy_pkg::MDIO_OP_WRITE : miiphy_pkg::MDIO_OP_READ,
                          mgmt.phy_addr, mgmt.reg_addr,
                          mgmt.write ? miiphy_pkg::MDIO_TA_WRITE : miiphy_pkg::MDIO_TA_READ,
                          mgmt.write ? mgmt.wdata : miiphy_pkg::MDIO_IDLE_DATA};
          s_next.dout = 1'b1;
          s_next.oe = 1'b1;
        end
      end
      default: begin
        if (s_reg.div == DIV_W'(HALF_CYC - 1)) begin
          s_next.div = '0;
          s_next.mdc = ~s_reg.mdc;
          if (!s_reg.mdc) begin
            // Rising edge: capture read data as the line shows it, pull-up gives ffff
            if (!s_reg.wr && s_reg.bit_cnt >= 7'(miiphy_pkg::MDIO_DATA_START)) begin
              s_next.rdata = {s_reg.rdata[14:0], s_reg.mdio_s2};
            end
          end else if (s_reg.bit_cnt == 7'(miiphy_pkg::MDIO_FRAME_BITS - 1)) begin
            s_next.state = miiphy_pkg::MIIPHY_MDIO_IDLE;
            s_next.done = 1'b1;
            s_next.oe = 1'b0;
            s_next.dout = 1'b1;
          end else begin
            s_next.bit_cnt = s_reg.bit_cnt + 7'h1;
            s_next.shreg = {s_reg.shreg[62:0], 1'b0};
            s_next.dout = s_reg.shreg[62];
            // Reads release the line from turnaround onward
            s_next.oe = s_reg.wr || (s_reg.bit_cnt + 7'h1 < 7'(miiphy_pkg::MDIO_RD_DRIVE));
          end
        end else begin
          s_next.div = s_reg.div + DIV_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.dout <= 1'b1;
      s_reg.mdio_s1 <= 1'b1;
      s_reg.mdio_s2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mdc_out    = s_reg.mdc;
  assign mdio_out   = s_reg.dout;
  assign mdio_oe    = s_reg.oe;
  assign mgmt.busy  = (s_reg.state == miiphy_pkg::MIIPHY_MDIO_RUN);
  assign mgmt.done  = s_reg.done;
  assign mgmt.rdata = s_reg.rdata;

endmodule : miiphy_mdio

// >>> src/miiphy_attach.sv
`timescale 1ns/1ps
// MAC-side attachment of an external PHY: nibble data path, sideband, management
module miiphy_attach #(
  parameter int unsigned MDC_HALF = miiphy_pkg::MDC_HALF_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Transmit stream from the MAC core
  input  wire logic        tx_valid,
  input  wire logic [3:0]  tx_nibble,
  input  wire logic        tx_error,
  output logic             tx_ready,
  output logic             tx_collision,
  // Receive stream to the MAC core
  output logic             rx_valid,
  output logic [3:0]       rx_nibble,
  output logic             rx_frame_end,
  output logic             rx_frame_err,
  // Status and sideband control
  output logic             full_duplex,
  output logic             phy_irq_event,
  output logic             fast_clock_alive,
  input  wire logic        phy_reset_req,
  // Management requests
  input  wire logic        mgmt_req,
  input  wire logic        mgmt_write,
  input  wire logic [4:0]  mgmt_phy_addr,
  input  wire logic [4:0]  mgmt_reg_addr,
  input  wire logic [15:0] mgmt_wdata,
  output logic             mgmt_busy,
  output logic             mgmt_done,
  output logic [15:0]      mgmt_rdata,
  // Nibble interface pins
  input  wire logic        mii_tx_clk,
  output logic [3:0]       mii_txd,
  output logic             mii_tx_en,
  output logic             mii_tx_er,
  input  wire logic        mii_rx_clk,
  input  wire logic [3:0]  mii_rxd,
  input  wire logic        mii_rx_dv,
  input  wire logic        mii_rx_er,
  input  wire logic        mii_col,
  input  wire logic        mii_crs,
  input  wire logic        mii_duplex_in,
  // Sideband pins
  input  wire logic        phy_fast_clock_in,
  input  wire logic        ext_phy_irq_low_in,
  output logic             ext_phy_rst_low_out,
  output logic             phy_reference_clock_out,
  // Management pins
  output logic             mdc_out,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe
);

  localparam int unsigned FW = miiphy_pkg::FAST_CNT_W;
  localparam int unsigned RW = miiphy_pkg::REF_CNT_W;

  // All registered state of the attach block except the management engine
  typedef struct packed {
    // Transmit clock sampling
    logic          txc_s1;
    logic          txc_s2;
    logic          txc_d;
    // Receive clock and qualifiers sampling
    logic          rxc_s1;
    logic          rxc_s2;
    logic          rxc_d;
    logic [3:0]    rxd_s1;
    logic [3:0]    rxd_s2;
    logic          dv_s1;
    logic          dv_s2;
    logic          er_s1;
    logic          er_s2;
    // Line status sampling
    logic          col_s1;
    logic          col_s2;
    logic          crs_s1;
    logic          crs_s2;
    logic          dup_s1;
    logic          dup_s2;
    logic          irq_s1;
    logic          irq_s2;
    logic          irq_d;
    logic          fast_s1;
    logic          fast_s2;
    logic          fast_d;
    // Transmit outputs
    logic [3:0]    txd;
    logic          tx_en;
    logic          tx_er;
    logic          tx_col;
    // Receive outputs
    logic          rx_vld;
    logic [3:0]    rx_nib;
    logic          rx_in_frame;
    logic          rx_err_acc;
    logic          rx_end;
    logic          rx_err;
    // Sideband outputs
    logic          irq_evt;
    logic          rst_low;
    logic [RW-1:0] ref_cnt;
    logic          ref_clk;
    logic [FW-1:0] fast_cnt;
  } miiphy_attach_reg_type;

  miiphy_attach_reg_type s_reg;
  miiphy_attach_reg_type s_next;

  logic tx_edge;
  logic rx_edge;
  logic half_dup;
  logic defer;
  logic tx_accept;

  miiphy_mgmt_if mgmt_bus ();

  // Edges of the link clocks, found after the two-stage synchronisers
  assign tx_edge  = s_reg.txc_s2 & ~s_reg.txc_d;
  assign rx_edge  = s_reg.rxc_s2 & ~s_reg.rxc_d;
  assign half_dup = ~s_reg.dup_s2;
  // Deferral only applies when a new frame would start
  assign defer     = half_dup & s_reg.crs_s2;
  assign tx_accept = tx_edge & tx_valid & (s_reg.tx_en | ~defer);

  // Next-state logic for the whole block
  always_comb begin
    s_next = s_reg;
    s_next.txc_s1  = mii_tx_clk;
    s_next.txc_s2  = s_reg.txc_s1;
    s_next.txc_d   = s_reg.txc_s2;
    s_next.rxc_s1  = mii_rx_clk;
    s_next.rxc_s2  = s_reg.rxc_s1;
    s_next.rxc_d   = s_reg.rxc_s2;
    s_next.rxd_s1  = mii_rxd;
    s_next.rxd_s2  = s_reg.rxd_s1;
    s_next.dv_s1   = mii_rx_dv;
    s_next.dv_s2   = s_reg.dv_s1;
    s_next.er_s1   = mii_rx_er;
    s_next.er_s2   = s_reg.er_s1;
    s_next.col_s1  = mii_col;
    s_next.col_s2  = s_reg.col_s1;
    s_next.crs_s1  = mii_crs;
    s_next.crs_s2  = s_reg.crs_s1;
    s_next.dup_s1  = mii_duplex_in;
    s_next.dup_s2  = s_reg.dup_s1;
    s_next.irq_s1  = ext_phy_irq_low_in;
    s_next.irq_s2  = s_reg.irq_s1;
    s_next.irq_d   = s_reg.irq_s2;
    s_next.fast_s1 = phy_fast_clock_in;
    s_next.fast_s2 = s_reg.fast_s1;
    s_next.fast_d  = s_reg.fast_s2;

    // Pulses default low
    s_next.tx_col  = 1'b0;
    s_next.rx_vld  = 1'b0;
    s_next.rx_end  = 1'b0;
    s_next.irq_evt = 1'b0;

    // Transmit: new nibble or idle is launched just after each clock rise.
    // The sampling delay is two to three sys_clk cycles, 10 to 15 ns, inside the 40 ns nibble time.
    if (tx_edge) begin
      s_next.tx_en = tx_accept;
      s_next.txd   = tx_accept ? tx_nibble : 4'h0;
      s_next.tx_er = tx_accept & tx_error;
    end

    // Collision reported only while sending in half duplex
    if (half_dup && s_reg.col_s2 && s_reg.tx_en) begin
      s_next.tx_col = 1'b1;
    end

    // Receive: sampled on the rise, data and qualifiers share the same delay
    if (rx_edge) begin
      if (s_reg.dv_s2) begin
        s_next.rx_vld      = 1'b1;
        s_next.rx_nib      = s_reg.rxd_s2;
        s_next.rx_in_frame = 1'b1;
        s_next.rx_err_acc  = s_reg.rx_err_acc | s_reg.er_s2;
      end else if (s_reg.rx_in_frame) begin
        // Frame closes on the first rise without valid data
        s_next.rx_end      = 1'b1;
        s_next.rx_err      = s_reg.rx_err_acc;
        s_next.rx_in_frame = 1'b0;
        s_next.rx_err_acc  = 1'b0;
      end
    end

    // Falling interrupt line becomes a one-cycle event
    if (!s_reg.irq_s2 && s_reg.irq_d) begin
      s_next.irq_evt = 1'b1;
    end

    // Reset output follows the request once out of local reset
    s_next.rst_low = ~phy_reset_req;

    // Free-running divide-by-eight reference clock
    if (s_reg.ref_cnt == RW'(miiphy_pkg::REF_HALF_CYC - 1)) begin
      s_next.ref_cnt = '0;
      s_next.ref_clk = ~s_reg.ref_clk;
    end else begin
      s_next.ref_cnt = s_reg.ref_cnt + RW'(1);
    end

    // The fast clock aliases against ours, but any toggle still proves it runs
    if (s_reg.fast_s2 != s_reg.fast_d) begin
      s_next.fast_cnt = FW'(miiphy_pkg::FAST_ALIVE_CYC);
    end else if (s_reg.fast_cnt != '0) begin
      s_next.fast_cnt = s_reg.fast_cnt - FW'(1);
    end
  end

  // State register; the PHY is held in reset while this block is
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.irq_s1 <= 1'b1;
      s_reg.irq_s2 <= 1'b1;
      s_reg.irq_d  <= 1'b1;
      s_reg.dup_s1 <= 1'b1;
      s_reg.dup_s2 <= 1'b1;
      s_reg.rst_low <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Management requests cross to the engine through the carrier
  assign mgmt_bus.req      = mgmt_req;
  assign mgmt_bus.write    = mgmt_write;
  assign mgmt_bus.phy_addr = mgmt_phy_addr;
  assign mgmt_bus.reg_addr = mgmt_reg_addr;
  assign mgmt_bus.wdata    = mgmt_wdata;
  assign mgmt_busy         = mgmt_bus.busy;
  assign mgmt_done         = mgmt_bus.done;
  assign mgmt_rdata        = mgmt_bus.rdata;

  // Serial management engine
  miiphy_mdio #(
    .HALF_CYC (MDC_HALF)
  ) u_mdio (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .mgmt     (mgmt_bus.engine),
    .mdc_out  (mdc_out),
    .mdio_in  (mdio_in),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe)
  );

  // Outputs: handshake and clock-alive flag are combinational, everything else from flip-flops
  assign tx_ready                = tx_accept;
  assign tx_collision            = s_reg.tx_col;
  assign mii_txd                 = s_reg.txd;
  assign mii_tx_en               = s_reg.tx_en;
  assign mii_tx_er               = s_reg.tx_er;
  assign rx_valid                = s_reg.rx_vld;
  assign rx_nibble               = s_reg.rx_nib;
  assign rx_frame_end            = s_reg.rx_end;
  assign rx_frame_err            = s_reg.rx_err;
  assign full_duplex             = s_reg.dup_s2;
  assign phy_irq_event           = s_reg.irq_evt;
  assign fast_clock_alive        = (s_reg.fast_cnt != '0);
  assign ext_phy_rst_low_out     = s_reg.rst_low;
  assign phy_reference_clock_out = s_reg.ref_clk;

endmodule : miiphy_attach

// >>> tb/miiphy_attach_assertions.sv
`timescale 1ns/1ps
// Port-level timing checks; all figures are sys_clk cycles
module miiphy_attach_assertions (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic [3:0] tx_nibble,
  input wire logic       tx_error,
  input wire logic       tx_ready,
  input wire logic       tx_collision,
  input wire logic       rx_valid,
  input wire logic       rx_frame_end,
  input wire logic       rx_frame_err,
  input wire logic       full_duplex,
  input wire logic       phy_irq_event,
  input wire logic       phy_reset_req,
  input wire logic [3:0] mii_txd,
  input wire logic       mii_tx_en,
  input wire logic       mii_tx_er,
  input wire logic       mii_rx_dv,
  input wire logic       mii_crs,
  input wire logic       mii_duplex_in,
  input wire logic       ext_phy_irq_low_in,
  input wire logic       ext_phy_rst_low_out,
  input wire logic       phy_reference_clock_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Transmit side: launch, deferral and collision reporting
  property p_tx_launch; tx_ready |=> mii_tx_en && mii_txd == $past(tx_nibble)
    && mii_tx_er == $past(tx_error); endproperty
  a_tx_launch: assert property (p_tx_launch) else $error("tx launch wrong");
  property p_tx_defer; (!full_duplex && mii_crs && !mii_tx_en)[*4] |-> !tx_ready; endproperty
  a_tx_defer: assert property (p_tx_defer) else $error("tx not deferred");
  property p_col; tx_collision |-> $past(mii_tx_en) && !$past(full_duplex); endproperty
  a_col: assert property (p_col) else $error("collision in full duplex");

  // Receive side: data only under valid, error flag moves only at frame end
  property p_rx_valid; rx_valid |-> $past(mii_rx_dv, 3); endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("rx data without valid");
  property p_rx_err; $changed(rx_frame_err) |-> rx_frame_end; endproperty
  a_rx_err: assert property (p_rx_err) else $error("frame error off frame end");

  // Sideband pins
  property p_duplex; $stable(mii_duplex_in)[*4] |-> full_duplex == mii_duplex_in; endproperty
  a_duplex: assert property (p_duplex) else $error("duplex status wrong");
  property p_irq; $fell(ext_phy_irq_low_in) |-> ##[2:5] phy_irq_event; endproperty
  a_irq: assert property (p_irq) else $error("irq event missing");
  property p_rst_out; !$past(sys_rst) |-> ext_phy_rst_low_out != $past(phy_reset_req);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("phy reset out wrong");
  property p_refclk; $rose(phy_reference_clock_out) |-> phy_reference_clock_out[*4]
    ##1 !phy_reference_clock_out[*4] ##1 phy_reference_clock_out; endproperty
  a_refclk: assert property (p_refclk) else $error("reference clock shape wrong");
endmodule : miiphy_attach_assertions

bind miiphy_attach miiphy_attach_assertions i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .tx_nibble(tx_nibble), .tx_error(tx_error), .tx_ready(tx_ready),
  .tx_collision(tx_collision), .rx_valid(rx_valid), .rx_frame_end(rx_frame_end),
  .rx_frame_err(rx_frame_err), .full_duplex(full_duplex), .phy_irq_event(phy_irq_event),
  .phy_reset_req(phy_reset_req), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en),
  .mii_tx_er(mii_tx_er), .mii_rx_dv(mii_rx_dv), .mii_crs(mii_crs),
  .mii_duplex_in(mii_duplex_in), .ext_phy_irq_low_in(ext_phy_irq_low_in),
  .ext_phy_rst_low_out(ext_phy_rst_low_out),
  .phy_reference_clock_out(phy_reference_clock_out));

// >>> tb/miiphy_phy_model.sv
`timescale 1ns/1ps
// Behavioural PHY: free-running nibble clocks, one receive frame per request
module miiphy_phy_model (
  input  wire logic [3:0]  mii_txd,
  input  wire logic        mii_tx_en,
  input  wire logic        mii_tx_er,
  input  wire logic        mdio_out,
  input  wire logic        mdio_oe,
  input  wire logic        rx_go,
  input  wire logic        rx_bad,
  input  wire logic [31:0] rx_word,
  input  wire logic        fast_en,
  output logic             mii_tx_clk,
  output logic             mii_rx_clk,
  output logic [3:0]       mii_rxd,
  output logic             mii_rx_dv,
  output logic             mii_rx_er,
  output logic             mdio_in,
  output logic             phy_fast_clock_in,
  output logic             rx_busy,
  output logic [31:0]      tx_got,
  output logic [7:0]       tx_cnt,
  output logic             tx_er_last
);
  int   rx_left = 0;
  logic fast_raw = 1'b0;

  // 48 ns period clocks; receive offset by 7 ns so it is unrelated to transmit
  initial begin
    {mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_rx_er, tx_er_last, mii_rxd, tx_got, tx_cnt} = 49'h0;
    #7;
    forever #24 mii_rx_clk = ~mii_rx_clk;
  end
  always #24 mii_tx_clk = ~mii_tx_clk;
  always #4 fast_raw = ~fast_raw;
  assign phy_fast_clock_in = fast_raw & fast_en;
  assign mdio_in = mdio_oe ? mdio_out : 1'b1;
  assign rx_busy = rx_left != 0 || mii_rx_dv;

  // Launch on the fall so the rise samples a settled nibble
  always @(negedge mii_rx_clk) begin
    if (rx_left == 0 && rx_go) rx_left = 8;
    mii_rx_dv <= rx_left != 0;
    if (rx_left != 0) begin
      mii_rxd <= rx_word[4*(8-rx_left)+:4];
      mii_rx_er <= rx_bad && rx_left == 4;
      rx_left = rx_left - 1;
    end else begin
      mii_rxd <= ~mii_rxd; // Idle garbage so stale data never passes
      mii_rx_er <= ~mii_rx_er;
    end
  end

  // Collect transmitted nibbles, low nibble first
  always @(posedge mii_tx_clk) if (mii_tx_en === 1'b1) begin
    tx_got <= {mii_txd, tx_got[31:4]};
    tx_cnt <= tx_cnt + 8'h01;
    tx_er_last <= mii_tx_er;
  end
endmodule : miiphy_phy_model

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic        sys_clk = 0, sys_rst = 1, tx_valid = 0, tx_error = 0, phy_reset_req = 0;
  logic        mgmt_req = 0, mgmt_write = 0, rx_go = 0, rx_bad = 0, fast_en = 0;
  logic        mii_col = 0, mii_crs = 0, ext_phy_irq_low_in = 1;
  logic        mii_duplex_in = 1;
  logic [3:0]  tx_nibble = 4'h0, mii_txd, mii_rxd, rx_nibble;
  logic [4:0]  mgmt_phy_addr = 5'h00, mgmt_reg_addr = 5'h00;
  logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata;
  logic [31:0] rx_word = 32'h0, rx_got, tx_got;
  logic [63:0] md_bits;
  logic [7:0]  tx_cnt;
  logic        tx_ready, tx_collision, rx_valid, rx_frame_end, rx_frame_err, full_duplex;
  logic        phy_irq_event, fast_clock_alive, mgmt_busy, mgmt_done, mii_tx_clk, mii_tx_en;
  logic        mii_tx_er, mii_rx_clk, mii_rx_dv, mii_rx_er, phy_fast_clock_in, rx_busy;
  logic        ext_phy_rst_low_out, phy_reference_clock_out, mdc_out, mdio_in, mdio_out;
  logic        mdio_oe, tx_er_last;
  int          seed = 76, n_mismatch = 0, checks = 0, n_rdy = 0, n_col = 0, n_irq = 0;
  int          n_rx = 0;

  always #2.5 sys_clk = ~sys_clk;

  miiphy_attach #(.MDC_HALF(2)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .tx_valid(tx_valid), .tx_nibble(tx_nibble), .tx_error(tx_error), .tx_ready(tx_ready),
    .tx_collision(tx_collision), .rx_valid(rx_valid), .rx_nibble(rx_nibble),
    .rx_frame_end(rx_frame_end), .rx_frame_err(rx_frame_err), .full_duplex(full_duplex),
    .phy_irq_event(phy_irq_event), .fast_clock_alive(fast_clock_alive),
    .phy_reset_req(phy_reset_req), .mgmt_req(mgmt_req), .mgmt_write(mgmt_write),
    .mgmt_phy_addr(mgmt_phy_addr), .mgmt_reg_addr(mgmt_reg_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_busy(mgmt_busy), .mgmt_done(mgmt_done), .mgmt_rdata(mgmt_rdata),
    .mii_tx_clk(mii_tx_clk), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er),
    .mii_rx_clk(mii_rx_clk), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er),
    .mii_col(mii_col), .mii_crs(mii_crs), .mii_duplex_in(mii_duplex_in),
    .phy_fast_clock_in(phy_fast_clock_in), .ext_phy_irq_low_in(ext_phy_irq_low_in),
    .ext_phy_rst_low_out(ext_phy_rst_low_out), .mdc_out(mdc_out), .mdio_in(mdio_in),
    .phy_reference_clock_out(phy_reference_clock_out), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  miiphy_phy_model i_phy (.mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rx_go(rx_go), .rx_bad(rx_bad), .rx_word(rx_word),
    .fast_en(fast_en), .mii_tx_clk(mii_tx_clk), .mii_rx_clk(mii_rx_clk), .mii_rxd(mii_rxd),
    .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mdio_in(mdio_in), .rx_busy(rx_busy),
    .phy_fast_clock_in(phy_fast_clock_in), .tx_got(tx_got), .tx_cnt(tx_cnt),
    .tx_er_last(tx_er_last));

  // Pulse counters sampled mid-cycle, after combinational outputs settle
  always @(negedge sys_clk) begin
    n_rdy += (tx_ready === 1'b1);
    n_col += (tx_collision === 1'b1);
    n_irq += (phy_irq_event === 1'b1);
  end
  always @(posedge sys_clk) if (rx_valid === 1'b1) begin
    rx_got <= {rx_nibble, rx_got[31:4]};
    n_rx <= n_rx + 1;
  end
  always @(posedge mdc_out) md_bits <= {md_bits[62:0], mdio_in};

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bits seen on MDC rises; a released line reads as ones
  function automatic logic [63:0] md_frame(input logic wr, input logic [4:0] pa, ra,
                                           input logic [15:0] d);
    return {32'hffffffff, 2'b01, wr ? 2'b01 : 2'b10, pa, ra, wr ? {2'b10, d} : 18'h3ffff};
  endfunction : md_frame

  // Eight nibbles, each held until taken; the tail lets the PHY catch the last
  task automatic tx_case(input logic [31:0] w, input logic bad);
    int         k;
    logic [7:0] c0;
    c0 = tx_cnt;
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      {tx_valid, tx_nibble, tx_error} = {1'b1, w[4*i+:4], bad && i == 7};
      #1;
      for (k = 0; tx_ready !== 1'b1 && k < 100; k++) begin
        @(negedge sys_clk);
        #1;
      end
      check(k < 100, 1);
    end
    @(negedge sys_clk);
    {tx_valid, tx_error} = 2'h0;
    repeat (30) @(negedge sys_clk);
    check(tx_got, w);
    check(8'(tx_cnt - c0), 8);
    check(tx_er_last, bad);
  endtask : tx_case

  task automatic rx_case(input logic [31:0] w, input logic bad);
    int k, c0;
    @(negedge sys_clk);
    {rx_word, rx_bad, rx_go} = {w, bad, 1'b1};
    {c0, k} = {n_rx, 32'h0};
    while (rx_busy !== 1'b1 && k < 100) begin @(negedge sys_clk); k++; end
    rx_go = 0;
    while (rx_frame_end !== 1'b1 && k < 400) begin @(negedge sys_clk); k++; end
    check(k < 400, 1);
    check(rx_got, w);
    check(n_rx - c0, 8);
    check(rx_frame_err, bad);
  endtask : rx_case

  // Request is held until busy, then dropped before any edge of it lands while busy
  task automatic mgmt(input logic wr, input logic [4:0] pa, ra, input logic [15:0] d);
    int k;
    @(negedge sys_clk);
    {mgmt_req, mgmt_write, mgmt_phy_addr, mgmt_reg_addr, mgmt_wdata} = {1'b1, wr, pa, ra, d};
    for (k = 0; mgmt_done !== 1'b1 && k < 2000; k++) begin
      @(negedge sys_clk);
      if (mgmt_busy === 1'b1) mgmt_req = 0;
    end
    check(k < 2000, 1);
    check(md_bits, md_frame(wr, pa, ra, d));
    if (!wr) check(mgmt_rdata, 16'hffff);
  endtask : mgmt

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    logic [31:0] w;
    repeat (6) @(negedge sys_clk);
    sys_rst = 0;
    @(negedge sys_clk);
    check({full_duplex, mdio_oe, mii_tx_en}, 3'h4);
    tx_case(32'hf000000f, 1'b1);
    rx_case(32'h0ff000f0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      tx_case(w, w[0]);
      rx_case(~w, w[1]);
    end
    $display("Test done: traffic");
    mgmt(1'b1, w[4:0], w[9:5], w[31:16]);
    mgmt(1'b0, 5'h1f, 5'h00, 16'h0000);
    $display("Test done: management");
    // Half duplex: carrier holds off the frame, collision is only reported; full duplex ignores both
    {mii_duplex_in, mii_crs} = 2'h1;
    repeat (8) @(negedge sys_clk);
    check(full_duplex, 0);
    {n_rdy, tx_valid} = {32'h0, 1'b1};
    repeat (60) @(negedge sys_clk);
    check(n_rdy, 0);
    {mii_crs, mii_col, n_col} = {2'h1, 32'h0};
    tx_case(w, 1'b0);
    check(n_col != 0, 1);
    {mii_duplex_in, mii_crs} = 2'h3;
    repeat (8) @(negedge sys_clk);
    n_col = 0;
    tx_case(~w, 1'b0);
    check(n_col, 0);
    {mii_col, mii_crs} = 2'h0;
    $display("Test done: duplex");
    {n_irq, ext_phy_irq_low_in} = {32'h0, 1'b0};
    repeat (10) @(negedge sys_clk);
    ext_phy_irq_low_in = 1;
    repeat (10) @(negedge sys_clk);
    check(n_irq, 1);
    phy_reset_req = 1;
    repeat (2) @(negedge sys_clk);
    check(ext_phy_rst_low_out, 0);
    phy_reset_req = 0;
    repeat (2) @(negedge sys_clk);
    check(ext_phy_rst_low_out, 1);
    fast_en = 1;
    repeat (80) @(negedge sys_clk);
    check(fast_clock_alive, 1);
    fast_en = 0;
    repeat (80) @(negedge sys_clk);
    check(fast_clock_alive, 0);
    $display("Test done: sideband");
    summarize();
  end

  // Watchdog: the whole run needs well under 20 us
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule : tb
